// ---- rtl/rgbq_map.svh ----
// register offsets, field widths, reset values and timing counts of the rgb output block
`ifndef RGBQ_MAP_SVH
`define RGBQ_MAP_SVH

// base of the register region and offsets inside it
`define RGBQ_REG_BASE      32'h0000_0000
`define RGBQ_OFF_PIN       32'h0000_0064
`define RGBQ_OFF_SPREAD    32'h0000_0068
`define RGBQ_OFF_EDGE      32'h0000_006c
`define RGBQ_OFF_DIV       32'h0000_0070
`define RGBQ_OFF_QX        32'h0000_0074
`define RGBQ_OFF_QY        32'h0000_0078
`define RGBQ_OFF_LABEL     32'h0000_007c

// field widths, all fields start at bit 0
`define RGBQ_PIN_W         4
`define RGBQ_DIV_W         8
`define RGBQ_COORD_W       11
`define RGBQ_TAG_W         8

// reset values
`define RGBQ_RST_PIN       4'h0
`define RGBQ_RST_SPREAD    1'h0
`define RGBQ_RST_EDGE      1'h0
`define RGBQ_RST_DIV       8'h00
`define RGBQ_RST_COORD     11'h000
`define RGBQ_RST_TAG       8'h00

// tag store tiling: coordinate bits from this position up pick a tile
`define RGBQ_TILE_SHIFT    7
`define RGBQ_TILE_BITS     4

// shortest pixel clock period in reference cycles
`define RGBQ_MIN_PERIOD    8'h02

`endif

// ---- rtl/rgbq_pclk_gen.sv ----
// pixel clock divider with period-boundary reload of divisor and edge choice
module rgbq_pclk_gen
   import rgbq_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // settings from registers
   input  wire logic [7:0] div,
   input  wire logic       fall,
   // outputs
   output logic            pclk,
   output logic            launch
);
`include "rgbq_map.svh"

   rgbq_pclk_st_t s_q;
   rgbq_pclk_st_t s_d;
   logic [7:0]    per;
   logic [7:0]    hi;
   logic [7:0]    nxt;
   logic          run;

   always_comb begin
      s_d = s_q;
      per = (s_q.div < `RGBQ_MIN_PERIOD) ? `RGBQ_MIN_PERIOD : s_q.div;
      run = 1'b1;
      nxt = s_q.cnt + 8'h01;
      if (s_q.div == 8'h00 || nxt >= per) begin
         // boundary: take new settings only here
         nxt      = 8'h00;
         s_d.div  = div;
         s_d.fall = fall;
         run      = (div != 8'h00);
      end
      per = (s_d.div < `RGBQ_MIN_PERIOD) ? `RGBQ_MIN_PERIOD : s_d.div;
      hi  = per - (per >> 1);
      s_d.cnt    = run ? nxt : 8'h00;
      // high from count 0 to hi-1, period = div cycles, at least 2
      s_d.pclk   = run & (s_d.cnt < hi);
      // data launched on the edge opposite the sampling edge
      s_d.launch = run & (s_d.fall ? (s_d.cnt == 8'h00) : (s_d.cnt == hi));
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign pclk   = s_q.pclk;
   assign launch = s_q.launch;

endmodule

// ---- rtl/rgbq_pkg.sv ----
// types shared by the rgb output and tag query block
package rgbq_pkg;

   typedef struct packed {
      logic [7:0] r;
      logic [7:0] g;
      logic [7:0] b;
   } rgbq_rgb_t;

   typedef enum logic [2:0] {
      SEL_NONE,
      SEL_PIN,
      SEL_SPREAD,
      SEL_EDGE,
      SEL_DIV,
      SEL_QX,
      SEL_QY,
      SEL_LABEL
   } rgbq_sel_t;

   typedef struct packed {
      logic [7:0] cnt;
      logic [7:0] div;
      logic       fall;
      logic       pclk;
      logic       launch;
   } rgbq_pclk_st_t;

   typedef struct packed {
      logic [255:0][7:0] mem;
      logic [7:0]        qa;
      logic [7:0]        qb;
   } rgbq_tag_st_t;

   typedef struct packed {
      logic [3:0]       pin;
      logic             spread;
      logic             fall;
      logic [7:0]       div;
      logic [10:0]      qx;
      logic [10:0]      qy;
      logic [7:0]       label;
      logic [7:0]       touch_tag;
      logic [31:0]      prdata;
      logic             pready;
      logic             pslverr;
      logic [2:0][7:0]  held;
      logic [2:0][7:0]  out;
      logic [1:0]       lag;
      logic             take;
   } rgbq_top_st_t;

endpackage

// ---- rtl/rgbq_tag_store.sv ----
// tiled tag store with one write port and two registered read ports
module rgbq_tag_store
   import rgbq_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // renderer write port
   input  wire logic        wr_en,
   input  wire logic [10:0] wr_x,
   input  wire logic [10:0] wr_y,
   input  wire logic [7:0]  wr_val,
   // read ports
   input  wire logic [10:0] qa_x,
   input  wire logic [10:0] qa_y,
   input  wire logic [10:0] qb_x,
   input  wire logic [10:0] qb_y,
   output logic      [7:0]  qa_tag,
   output logic      [7:0]  qb_tag
);
`include "rgbq_map.svh"

   rgbq_tag_st_t s_q;
   rgbq_tag_st_t s_d;

   function automatic logic [7:0] tile(input logic [10:0] x, input logic [10:0] y);
      tile = {y[`RGBQ_TILE_SHIFT +: `RGBQ_TILE_BITS], x[`RGBQ_TILE_SHIFT +: `RGBQ_TILE_BITS]};
   endfunction

   always_comb begin
      s_d = s_q;
      if (wr_en) begin
         s_d.mem[tile(wr_x, wr_y)] = wr_val;
      end
      s_d.qa = s_q.mem[tile(qa_x, qa_y)];
      s_d.qb = s_q.mem[tile(qb_x, qb_y)];
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign qa_tag = s_q.qa;
   assign qb_tag = s_q.qb;

endmodule

// ---- rtl/rgbq_top.sv ----
// apb register file, pixel output stage and tag query of the rgb panel interface
////////////////////////////////////////////////////////////////////////////////
//
// Contract
// - reserved bits read as zero and writes to them are dropped.
// - every register occupies one 32-bit word.
// - offsets are decoded relative to the register region base.
// - the label register at 0x7c shows the tag at the queried x and y in bits 7 to 0.
// - a separate touch tag follows the touch point, independent of the query.
// - query y at 0x78 holds 11 bits in 10 to 0 and resets to 0.
// - query x at 0x74 holds 11 bits in 10 to 0 and resets to 0.
// - the pixel clock is the reference clock divided by bits 7 to 0 at 0x70, a divider of 1 dividing by 2.
// - a divider of zero stops the pixel clock, which is the reset state.
// - bit 0 at 0x6c picks the sampling edge, 0 rising and 1 falling.
// - bit 0 at 0x68 makes the colour lines change together or staggered.
// - bits 3 to 0 at 0x64 choose the colour pin arrangement and reset to 0.
module rgbq_top
   import rgbq_pkg::*;
(
   // clock and reset
   input  wire logic        REF_CLK,
   input  wire logic        RSTN,
   // apb slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [31:0] PADDR,
   input  wire logic [31:0] PWDATA,
   input  wire logic [3:0]  PSTRB,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // pixel source
   input  wire rgbq_rgb_t   PIX_DATA,
   output logic             PIX_TAKE,
   // panel pins
   output logic             PCLK,
   output rgbq_rgb_t        RGB_OUT,
   // renderer tag writes
   input  wire logic        TAG_WR_EN,
   input  wire logic [10:0] TAG_WR_X,
   input  wire logic [10:0] TAG_WR_Y,
   input  wire logic [7:0]  TAG_WR_VAL,
   // touch point
   input  wire logic [10:0] TOUCH_X,
   input  wire logic [10:0] TOUCH_Y,
   output logic      [7:0]  TOUCH_TAG
);
`include "rgbq_map.svh"

   ////////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic rgbq_sel_t reg_sel(input logic [31:0] addr);
      logic [31:0] rel;
      rel = addr - `RGBQ_REG_BASE;
      case (rel)
         `RGBQ_OFF_PIN:    reg_sel = SEL_PIN;
         `RGBQ_OFF_SPREAD: reg_sel = SEL_SPREAD;
         `RGBQ_OFF_EDGE:   reg_sel = SEL_EDGE;
         `RGBQ_OFF_DIV:    reg_sel = SEL_DIV;
         `RGBQ_OFF_QX:     reg_sel = SEL_QX;
         `RGBQ_OFF_QY:     reg_sel = SEL_QY;
         `RGBQ_OFF_LABEL:  reg_sel = SEL_LABEL;
         default:          reg_sel = SEL_NONE;
      endcase
   endfunction

   // byte-lane merge of a write into a 32-bit word
   function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  strb);
      lane_merge = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            lane_merge[8*i +: 8] = wd[8*i +: 8];
         end
      end
   endfunction

   // channel order then per-channel bit reversal
   function automatic logic [2:0][7:0] arrange(input logic [23:0] pix, input logic [3:0] code);
      logic [2:0][7:0] c;
      logic [2:0][7:0] o;
      c = pix;
      case (code[2:0])
         3'h1:    o = {c[2], c[0], c[1]};
         3'h2:    o = {c[1], c[2], c[0]};
         3'h3:    o = {c[1], c[0], c[2]};
         3'h4:    o = {c[0], c[2], c[1]};
         3'h5:    o = {c[0], c[1], c[2]};
         default: o = c;
      endcase
      if (code[3]) begin
         for (int k = 0; k < 3; k++) begin
            o[k] = {<<{o[k]}};
         end
      end
      arrange = o;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // state

   rgbq_top_st_t    s_q;
   rgbq_top_st_t    s_d;
   rgbq_sel_t       sel;
   logic            acc;
   logic            wr_fire;
   logic [31:0]     cur;
   logic [31:0]     nw;
   logic [2:0][7:0] swz;
   logic            launch;
   logic            pclk_w;
   logic [7:0]      qa_tag;
   logic [7:0]      qb_tag;

   ////////////////////////////////////////////////////////////////////////////////
   // pixel clock and tag store

   rgbq_pclk_gen u_pclk (
      .clk    (REF_CLK),
      .rst_n  (RSTN),
      .div    (s_q.div),
      .fall   (s_q.fall),
      .pclk   (pclk_w),
      .launch (launch)
   );

   rgbq_tag_store u_tags (
      .clk    (REF_CLK),
      .rst_n  (RSTN),
      .wr_en  (TAG_WR_EN),
      .wr_x   (TAG_WR_X),
      .wr_y   (TAG_WR_Y),
      .wr_val (TAG_WR_VAL),
      .qa_x   (s_q.qx),
      .qa_y   (s_q.qy),
      .qb_x   (TOUCH_X),
      .qb_y   (TOUCH_Y),
      .qa_tag (qa_tag),
      .qb_tag (qb_tag)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      s_d     = s_q;
      sel     = reg_sel(PADDR);
      acc     = PSEL & PENABLE;
      wr_fire = acc & PWRITE & s_q.pready;

      // current word, reserved bits zero
      case (sel)
         SEL_PIN:    cur = 32'(s_q.pin);
         SEL_SPREAD: cur = 32'(s_q.spread);
         SEL_EDGE:   cur = 32'(s_q.fall);
         SEL_DIV:    cur = 32'(s_q.div);
         SEL_QX:     cur = 32'(s_q.qx);
         SEL_QY:     cur = 32'(s_q.qy);
         SEL_LABEL:  cur = 32'(s_q.label);
         default:    cur = 32'h0000_0000;
      endcase
      nw = lane_merge(cur, PWDATA, PSTRB);

      // answer one cycle into the access phase
      s_d.pready  = acc & ~s_q.pready;
      // error flag only stands with its ready pulse
      s_d.pslverr = 1'b0;
      if (acc & ~s_q.pready) begin
         s_d.prdata  = PWRITE ? 32'h0000_0000 : cur;
         s_d.pslverr = (sel == SEL_NONE) | (PWRITE & (sel == SEL_LABEL));
      end

      // writes land at the edge where pready is seen high
      if (wr_fire) begin
         case (sel)
            SEL_PIN:    s_d.pin    = nw[`RGBQ_PIN_W-1:0];
            SEL_SPREAD: s_d.spread = nw[0];
            SEL_EDGE:   s_d.fall   = nw[0];
            SEL_DIV:    s_d.div    = nw[`RGBQ_DIV_W-1:0];
            SEL_QX:     s_d.qx     = nw[`RGBQ_COORD_W-1:0];
            SEL_QY:     s_d.qy     = nw[`RGBQ_COORD_W-1:0];
            default:    s_d.pin    = s_q.pin;
         endcase
      end

      // tag results
      s_d.label     = qa_tag;
      s_d.touch_tag = qb_tag;

      // pixel output: launch takes a pixel, spread staggers the channels
      swz      = arrange(PIX_DATA, s_q.pin);
      s_d.take = launch;
      s_d.lag  = {s_q.lag[0], launch & s_q.spread};
      if (launch) begin
         s_d.held = swz;
      end
      for (int i = 0; i < 3; i++) begin
         if (launch && (!s_q.spread || i == 2)) begin
            s_d.out[i] = swz[i];
         end else if (s_q.spread && i == 1 && s_q.lag[0]) begin
            s_d.out[i] = s_q.held[i];
         end else if (s_q.spread && i == 0 && s_q.lag[1]) begin
            s_d.out[i] = s_q.held[i];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         s_q        <= '0;
         s_q.pin    <= `RGBQ_RST_PIN;
         s_q.spread <= `RGBQ_RST_SPREAD;
         s_q.fall   <= `RGBQ_RST_EDGE;
         s_q.div    <= `RGBQ_RST_DIV;
         s_q.qx     <= `RGBQ_RST_COORD;
         s_q.qy     <= `RGBQ_RST_COORD;
         s_q.label  <= `RGBQ_RST_TAG;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs

   assign PRDATA    = s_q.prdata;
   assign PREADY    = s_q.pready;
   assign PSLVERR   = s_q.pslverr;
   assign PIX_TAKE  = s_q.take;
   assign PCLK      = pclk_w;
   assign RGB_OUT   = s_q.out;
   assign TOUCH_TAG = s_q.touch_tag;

endmodule

// ---- verification/rgbq_asserts.sv ----
// port checks of the rgb output and tag query block
module rgbq_asserts
   import rgbq_pkg::*;
(
   // clock and reset
   input logic        REF_CLK,
   input logic        RSTN,
   // apb
   input logic        PSEL,
   input logic        PENABLE,
   input logic        PWRITE,
   input logic [31:0] PADDR,
   input logic [31:0] PRDATA,
   input logic        PREADY,
   input logic        PSLVERR,
   // pixel side
   input logic        PIX_TAKE,
   input logic        PCLK
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RSTN);
   sequence acc_s;
      PSEL && PENABLE && !PREADY;
   endsequence
   wait_state_a: assert property (acc_s |=> PREADY)
      else $error("no answer after one wait state");
   ready_pulse_a: assert property (PREADY |=> !PREADY)
      else $error("ready held too long");
   err_ready_a: assert property (PSLVERR |-> PREADY)
      else $error("error without ready");
   unmapped_err_a: assert property (acc_s ##0 (PADDR[31:7] != 0 || PADDR < 32'h64)
      |=> PSLVERR && PRDATA == 32'h0) else $error("unmapped access not refused");
   label_ro_a: assert property (acc_s ##0 (PWRITE && PADDR == 32'h7c) |=> PSLVERR)
      else $error("label write not refused");
   rsvd_zero_a: assert property (PREADY && !PSLVERR |-> PRDATA[31:11] == 21'h0)
      else $error("reserved read bits set");
   take_edge_a: assert property (PIX_TAKE |-> $past(PCLK) != $past(PCLK, 2))
      else $error("pixel taken away from a clock edge");
   take_gap_a: assert property (PIX_TAKE |=> !PIX_TAKE)
      else $error("two pixels in one period");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind rgbq_top rgbq_asserts u_rgbq_asserts (.REF_CLK(REF_CLK), .RSTN(RSTN), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
   .PSLVERR(PSLVERR), .PIX_TAKE(PIX_TAKE), .PCLK(PCLK));

// ---- verification/rgbq_panel.sv ----
// panel model that latches the colour pins on its active pixel clock edge
module rgbq_panel
   import rgbq_pkg::*;
(
   // panel pins
   input  logic      pclk,
   input  rgbq_rgb_t rgb,
   // edge choice, 1 for falling
   input  logic      fall,
   // last latched pixel
   output rgbq_rgb_t px
);
   timeunit 1ns;
   timeprecision 1ps;
   always @(pclk) if ((pclk ^ fall) === 1'b1) px <= rgb;
endmodule

// ---- verification/tb_top.sv ----
// self-checking bench of the rgb output and tag query block
`include "rgbq_map.svh"
module tb_top
   import rgbq_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, twe = 0, fall = 0, er;
   logic [31:0] padr = 0, pwd = 0, rd, prdata;
   logic [10:0] twx = 0, twy = 0, tx = 0, ty = 0;
   logic [7:0]  twv = 0, ttag;
   logic        pready, pslverr, take, pclk, pq = 0;
   rgbq_rgb_t   pix = 24'h112233, rgb, ppx;
   int          failures = 0, check_count = 0, cyc = 0, lp = 0, mp = 999;
   int          dv [4] = '{4, 5, 6, 2};
   logic [31:0] off [6] = '{`RGBQ_OFF_PIN, `RGBQ_OFF_SPREAD, `RGBQ_OFF_EDGE, `RGBQ_OFF_DIV,
                           `RGBQ_OFF_QX, `RGBQ_OFF_QY};
   logic [31:0] msk [6] = '{32'hf, 32'h1, 32'h1, 32'hff, 32'h7ff, 32'h7ff};
   logic [3:0]  cd [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'hd};
   logic [23:0] stg [3] = '{24'haa2233, 24'haabb33, 24'haabbcc};
////////////////////////////////////////////////////////////////////////////////
   rgbq_top u_rgbq_top (.REF_CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
      .PADDR(padr), .PWDATA(pwd), .PSTRB(4'hf), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .PIX_DATA(pix), .PIX_TAKE(take), .PCLK(pclk), .RGB_OUT(rgb),
      .TAG_WR_EN(twe), .TAG_WR_X(twx), .TAG_WR_Y(twy), .TAG_WR_VAL(twv), .TOUCH_X(tx),
      .TOUCH_Y(ty), .TOUCH_TAG(ttag));
   rgbq_panel u_rgbq_panel (.pclk(pclk), .rgb(rgb), .fall(fall), .px(ppx));
   always #4 clk = ~clk;
   // last pixel clock period and the shortest one seen
   always @(posedge clk) begin
      cyc++;
      if (pclk === 1'b1 && !pq) begin
         lp = cyc;
         if (cyc < mp) mp = cyc;
         cyc = 0;
      end
      pq = pclk === 1'b1;
   end
////////////////////////////////////////////////////////////////////////////////
   task automatic test_done;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic apb(logic w, logic [31:0] a, logic [31:0] d);
      int n;
      psel <= 1;
      pwr <= w;
      padr <= `RGBQ_REG_BASE + a;
      pwd <= d;
      @(posedge clk);
      pen <= 1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         failures++;
         test_done;
      end
      rd = prdata;
      er = pslverr;
      psel <= 0;
      pen <= 0;
      @(posedge clk);
   endtask
   task automatic wr(logic [31:0] a, logic [31:0] d);
      apb(1, a, d);
   endtask
   task automatic rdc(logic [31:0] a, logic [31:0] e);
      apb(0, a, 0);
      chk("read", e, rd);
      chk("read err", 0, er);
   endtask
   task automatic takew;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (take !== 1'b1 && n < 600);
      if (take !== 1'b1) begin
         failures++;
         test_done;
      end
   endtask
   task automatic quiet;
      int h;
      h = 0;
      repeat (30) begin
         @(posedge clk);
         h += (pclk !== 1'b0);
      end
      chk("clock stopped", 0, h);
   endtask
   function automatic logic [23:0] arr(logic [3:0] c, rgbq_rgb_t p);
      logic [7:0] a, b, d;
      case (c[2:0])
         3'h1: {a, b, d} = {p.r, p.b, p.g};
         3'h2: {a, b, d} = {p.g, p.r, p.b};
         3'h3: {a, b, d} = {p.g, p.b, p.r};
         3'h4: {a, b, d} = {p.b, p.r, p.g};
         3'h5: {a, b, d} = {p.b, p.g, p.r};
         default: {a, b, d} = p;
      endcase
      if (c[3]) begin
         a = {<<{a}};
         b = {<<{b}};
         d = {<<{d}};
      end
      return {a, b, d};
   endfunction
////////////////////////////////////////////////////////////////////////////////
   initial begin
      int i, f, pv;
      repeat (2) @(posedge clk);
      rstn <= 1;
      @(posedge clk);
      for (i = 0; i < 6; i++) rdc(off[i], 0);
      rdc(`RGBQ_OFF_LABEL, 0);
      quiet;
      for (i = 0; i < 6; i++) begin
         wr(off[i], '1);
         rdc(off[i], msk[i]);
      end
      apb(0, 32'h80, 0);
      chk("unmapped err", 1, er);
      chk("unmapped data", 0, rd);
      apb(1, `RGBQ_OFF_LABEL, '1);
      chk("label write err", 1, er);
      rdc(`RGBQ_OFF_LABEL, 0);
      // tag query and touch tag
      twx <= 11'h0c8;
      twy <= 11'h12c;
      twv <= 8'h5a;
      twe <= 1;
      tx <= 11'h0c8;
      ty <= 11'h12c;
      @(posedge clk);
      twe <= 0;
      wr(`RGBQ_OFF_QX, 32'h0c8);
      wr(`RGBQ_OFF_QY, 32'h12c);
      rdc(`RGBQ_OFF_LABEL, 32'h5a);
      wr(`RGBQ_OFF_QX, 0);
      rdc(`RGBQ_OFF_LABEL, 0);
      chk("touch tag", 8'h5a, ttag);
      // divider periods and clean switching
      wr(`RGBQ_OFF_SPREAD, 0);
      pv = 255;
      for (i = 0; i < 4; i++) begin
         mp = 999;
         wr(`RGBQ_OFF_DIV, dv[i]);
         repeat (600) @(posedge clk);
         chk("period", dv[i], lp);
         chk("no short period", 1, mp >= (pv < dv[i] ? pv : dv[i]));
         pv = dv[i];
      end
      // pin arrangement on both edges
      wr(`RGBQ_OFF_DIV, 8);
      for (f = 0; f < 2; f++) begin
         fall <= f[0];
         wr(`RGBQ_OFF_EDGE, f);
         foreach (cd[i]) begin
            wr(`RGBQ_OFF_PIN, cd[i]);
            takew;
            takew;
            chk("launch edge", f, pclk);
            chk("pins", arr(cd[i], pix), rgb);
            repeat (8) @(posedge clk);
            chk("panel pixel", arr(cd[i], pix), ppx);
         end
      end
      // colour lines together, then staggered
      fall <= 0;
      wr(`RGBQ_OFF_EDGE, 0);
      wr(`RGBQ_OFF_PIN, 0);
      for (f = 0; f < 2; f++) begin
         wr(`RGBQ_OFF_SPREAD, f);
         pix <= 24'h112233;
         takew;
         takew;
         pix <= 24'haabbcc;
         takew;
         for (i = 0; i < 3; i++) begin
            chk("colour lines", f ? stg[i] : 24'haabbcc, rgb);
            @(posedge clk);
         end
      end
      wr(`RGBQ_OFF_DIV, 0);
      repeat (20) @(posedge clk);
      quiet;
      test_done;
   end
endmodule
